// >>> hdl/poled_pkg.sv
/*
  Shared constants, register map and carrier types of the port owner LED driver.
  Assumes a single 20 MHz core clock and a classic Wishbone register bus.
*/
package poled_pkg;

  localparam int NUM_PORTS = 4;

  // Timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int CLK_HZ = 20_000_000;
  localparam int TOGGLE_HZ = 1000;
  localparam int TOGGLE_HALF_CYC = CLK_HZ / (2 * TOGGLE_HZ);
  localparam int STRAP_DELAY_NS = 1500;
  localparam int STRAP_DELAY_CYC = (STRAP_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Register byte addresses
  localparam logic [7:0] REG_CTRL_OFS = 8'h00;
  localparam logic [7:0] REG_STAT_OFS = 8'h04;
  localparam logic [7:0] REG_PINS_OFS = 8'h08;

  // Control register layout and reset values
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_INTDEF_BIT = 2;
  localparam int CTRL_POL_LSB = 8;
  localparam logic [1:0] CTRL_MODE_RST = 2'h0;
  localparam logic CTRL_INTDEF_RST = 1'b1;
  localparam logic [7:0] CTRL_POL_RST = 8'hff;

  // Status register layout
  localparam int STAT_STRAP_LSB = 0;
  localparam int STAT_RUN_BIT = 4;
  localparam int STAT_SUSP_BIT = 5;
  localparam int STAT_POL_LSB = 8;

  // Built-in polarity of the B pins, which have no strap
  localparam logic DEF_B_ACT_LOW = 1'b1;

  typedef enum logic [1:0] {
    MODE_USB = 2'h0,
    MODE_OWNER = 2'h1,
    MODE_SPEED = 2'h2
  } poled_mode_type;

  typedef enum logic [1:0] {
    OWN_NONE = 2'h0,
    OWN_A = 2'h1,
    OWN_B = 2'h2
  } poled_owner_type;

  typedef enum logic [1:0] {
    ST_WAIT = 2'b01,
    ST_RUN = 2'b10
  } poled_state_type;

  typedef struct packed {
    logic enabled;
    poled_owner_type owner;
    logic attached;
    logic high_speed;
    logic green;
    logic amber;
  } poled_port_type;

  typedef struct packed {
    logic val;
    logic oe_n;
  } poled_pin_type;

endpackage

// >>> hdl/poled_sync.sv
/*
  Three-stage synchroniser for a group of pin inputs with agreement filter.
  Assumes asynchronous pin levels and the single core clock.
*/
`timescale 1ns/1ps
module poled_sync
  import poled_pkg::*;
#(
  parameter int WIDTH = NUM_PORTS
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_stable
);

  logic [WIDTH-1:0] s1_r;
  logic [WIDTH-1:0] s2_r;
  logic [WIDTH-1:0] s3_r;
  logic [WIDTH-1:0] stable_r;

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= i_async;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // A bit moves only once the second and third stages agree
  generate
    for (genvar g = 0; g < WIDTH; g++) begin : g_bit
      always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
          stable_r[g] <= 1'b0;
        end else if (s2_r[g] == s3_r[g]) begin
          stable_r[g] <= s3_r[g];
        end
      end
    end
  endgenerate

  assign o_stable = stable_r;

endmodule // poled_sync

// >>> hdl/poled_tick.sv
/*
  Free-running divider producing the indicator toggle square wave.
  Assumes the core clock runs continuously.
*/
`timescale 1ns/1ps
module poled_tick
  import poled_pkg::*;
#(
  parameter int HALF_CYC = TOGGLE_HALF_CYC
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  output logic o_wave
);

  localparam int CNT_W = (HALF_CYC > 1) ? $clog2(HALF_CYC) : 1;

  logic [CNT_W-1:0] cnt_r;
  logic wave_r;

  // Equal high and low halves keep the mixed colour even
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      cnt_r <= '0;
      wave_r <= 1'b0;
    end else if (cnt_r == CNT_W'(HALF_CYC - 1)) begin
      cnt_r <= '0;
      wave_r <= ~wave_r;
    end else begin
      cnt_r <= cnt_r + CNT_W'(1);
    end
  end

  assign o_wave = wave_r;

endmodule // poled_tick

// >>> hdl/poled_top.sv
/*
  Indicator pin driver for a four-port, two-host switching hub: three display
  modes, strap sampling of the A pins after reset and a Wishbone register file.
  Assumes port status comes from hub logic on the same clock and that the
  board resolves each pin from value and active-low output enable.
*/
`timescale 1ns/1ps
module poled_top
  import poled_pkg::*;
#(
  parameter int P_TOGGLE_HALF_CYC = TOGGLE_HALF_CYC,
  parameter int P_STRAP_DELAY_CYC = STRAP_DELAY_CYC
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  // Wishbone slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [31:0] i_wb_dat,
  input wire logic [3:0] i_wb_sel,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // Hub state
  input wire poled_port_type [NUM_PORTS-1:0] i_port_stat,
  input wire logic i_hub_suspend,
  // Indicator pins
  input wire logic [NUM_PORTS-1:0] i_host_a_indicator_pins,
  output logic [NUM_PORTS-1:0] o_host_a_indicator_pins,
  output logic [NUM_PORTS-1:0] o_host_a_indicator_pins_oe_n,
  output logic [NUM_PORTS-1:0] o_host_b_indicator_pins,
  output logic [NUM_PORTS-1:0] o_host_b_indicator_pins_oe_n
);

  localparam int SCNT_W = (P_STRAP_DELAY_CYC > 1) ? $clog2(P_STRAP_DELAY_CYC + 1) : 1;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  poled_state_type state_r;
  logic [SCNT_W-1:0] scnt_r;
  logic [NUM_PORTS-1:0] strap_r;
  logic [NUM_PORTS-1:0] a_pin_stable;
  logic wave;

  poled_mode_type mode_r;
  logic intdef_r;
  logic [7:0] pol_r;

  logic [NUM_PORTS-1:0] a_act_low;
  logic [NUM_PORTS-1:0] b_act_low;

  poled_pin_type [NUM_PORTS-1:0] a_pin_r;
  poled_pin_type [NUM_PORTS-1:0] b_pin_r;
  poled_pin_type [NUM_PORTS-1:0] a_pin_nxt;
  poled_pin_type [NUM_PORTS-1:0] b_pin_nxt;

  logic wb_req;
  logic wb_wr;
  logic ack_r;
  logic [31:0] rdat_r;
  logic [31:0] rdat_nxt;
  logic [31:0] stat_word;
  logic [31:0] pins_word;

  ////////////////////////////////////////////////////////////////////////////
  // Strap capture and toggle source

  poled_sync #(
    .WIDTH(NUM_PORTS)
  ) u_strap_sync (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_async(i_host_a_indicator_pins),
    .o_stable(a_pin_stable)
  );

  poled_tick #(
    .HALF_CYC(P_TOGGLE_HALF_CYC)
  ) u_tick (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .o_wave(wave)
  );

  // Pins stay undriven until the straps are in, so the pads read the
  // board resistors and not our own drive.
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      state_r <= ST_WAIT;
      scnt_r <= '0;
    end else begin
      unique case (state_r)
        ST_WAIT: begin
          if (scnt_r == SCNT_W'(P_STRAP_DELAY_CYC)) begin
            state_r <= ST_RUN;
          end else begin
            scnt_r <= scnt_r + SCNT_W'(1);
          end
        end
        ST_RUN: begin
          state_r <= ST_RUN;
        end
        default: begin
          state_r <= ST_WAIT;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      strap_r <= '0;
    end else if (state_r == ST_WAIT && scnt_r == SCNT_W'(P_STRAP_DELAY_CYC)) begin
      strap_r <= a_pin_stable;
    end
  end

  // Strap high means active low, strap low means active high. Outside the
  // internal-default mode software sets polarity through the control word.
  always_comb begin
    if (intdef_r) begin
      a_act_low = strap_r;
      b_act_low = {NUM_PORTS{DEF_B_ACT_LOW}};
    end else begin
      a_act_low = pol_r[NUM_PORTS-1:0];
      b_act_low = pol_r[2*NUM_PORTS-1:NUM_PORTS];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-port drive

  generate
    for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
      poled_port_type st;
      logic owned;
      logic on_a;
      logic on_b;
      poled_pin_type spd;

      assign st = i_port_stat[p];
      // Host connection state is never looked at, so ownership stays lit
      // through suspend and with the owning host gone.
      assign owned = st.enabled && (st.owner != OWN_NONE);
      assign on_a = owned && (st.owner == OWN_A);
      assign on_b = owned && (st.owner == OWN_B);

      // Speed level follows the enumerated speed even in suspend; only the
      // empty-port toggle gives way to the hub suspend.
      always_comb begin
        spd = '{val: 1'b0, oe_n: 1'b1};
        if (st.attached) begin
          spd = '{val: st.high_speed, oe_n: 1'b0};
        end else if (!i_hub_suspend) begin
          spd = '{val: wave, oe_n: 1'b0};
        end else begin
          spd = '{val: 1'b0, oe_n: 1'b1};
        end
      end

      always_comb begin
        a_pin_nxt[p] = '{val: 1'b0, oe_n: 1'b1};
        b_pin_nxt[p] = '{val: 1'b0, oe_n: 1'b1};
        unique case (mode_r)
          MODE_USB: begin
            // Ownership is not visible here
            a_pin_nxt[p] = '{val: st.green ^ a_act_low[p], oe_n: 1'b0};
            b_pin_nxt[p] = '{val: st.amber ^ b_act_low[p], oe_n: 1'b0};
          end
          MODE_OWNER: begin
            a_pin_nxt[p] = '{val: on_a ^ a_act_low[p], oe_n: 1'b0};
            b_pin_nxt[p] = '{val: on_b ^ b_act_low[p], oe_n: 1'b0};
          end
          MODE_SPEED: begin
            // Dual-colour LEDs: raw level, polarity does not apply
            if (on_a) begin
              a_pin_nxt[p] = spd;
            end
            if (on_b) begin
              b_pin_nxt[p] = spd;
            end
          end
          default: begin
            a_pin_nxt[p] = '{val: 1'b0, oe_n: 1'b1};
            b_pin_nxt[p] = '{val: 1'b0, oe_n: 1'b1};
          end
        endcase
      end

      always_ff @(posedge i_clk) begin
        if (!i_nrst || state_r != ST_RUN) begin
          a_pin_r[p] <= '{val: 1'b0, oe_n: 1'b1};
          b_pin_r[p] <= '{val: 1'b0, oe_n: 1'b1};
        end else begin
          a_pin_r[p] <= a_pin_nxt[p];
          b_pin_r[p] <= b_pin_nxt[p];
        end
      end

      assign o_host_a_indicator_pins[p] = a_pin_r[p].val;
      assign o_host_a_indicator_pins_oe_n[p] = a_pin_r[p].oe_n;
      assign o_host_b_indicator_pins[p] = b_pin_r[p].val;
      assign o_host_b_indicator_pins_oe_n[p] = b_pin_r[p].oe_n;

      assign pins_word[4*p +: 4] = {b_pin_r[p].oe_n, b_pin_r[p].val,
                                    a_pin_r[p].oe_n, a_pin_r[p].val};
    end
  endgenerate

  assign pins_word[31:4*NUM_PORTS] = '0;

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone slave

  assign wb_req = i_wb_cyc && i_wb_stb && !ack_r;
  assign wb_wr = wb_req && i_wb_we;

  // Single wait state: ack one edge after the request, dropped the next
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= wb_req;
    end
  end

  // The reserved code is refused, so the mode is always one of three
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      mode_r <= poled_mode_type'(CTRL_MODE_RST);
      intdef_r <= CTRL_INTDEF_RST;
    end else if (wb_wr && i_wb_adr == REG_CTRL_OFS && i_wb_sel[0]) begin
      intdef_r <= i_wb_dat[CTRL_INTDEF_BIT];
      if (i_wb_dat[CTRL_MODE_LSB +: 2] != 2'h3) begin
        mode_r <= poled_mode_type'(i_wb_dat[CTRL_MODE_LSB +: 2]);
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      pol_r <= CTRL_POL_RST;
    end else if (wb_wr && i_wb_adr == REG_CTRL_OFS && i_wb_sel[1]) begin
      pol_r <= i_wb_dat[CTRL_POL_LSB +: 8];
    end
  end

  always_comb begin
    stat_word = '0;
    stat_word[STAT_STRAP_LSB +: NUM_PORTS] = strap_r;
    stat_word[STAT_RUN_BIT] = (state_r == ST_RUN);
    stat_word[STAT_SUSP_BIT] = i_hub_suspend;
    stat_word[STAT_POL_LSB +: 2*NUM_PORTS] = {b_act_low, a_act_low};
  end

  // Unmapped addresses read zero and ignore writes
  always_comb begin
    rdat_nxt = '0;
    unique case (i_wb_adr)
      REG_CTRL_OFS: begin
        rdat_nxt[CTRL_MODE_LSB +: 2] = mode_r;
        rdat_nxt[CTRL_INTDEF_BIT] = intdef_r;
        rdat_nxt[CTRL_POL_LSB +: 8] = pol_r;
      end
      REG_STAT_OFS: begin
        rdat_nxt = stat_word;
      end
      REG_PINS_OFS: begin
        rdat_nxt = pins_word;
      end
      default: begin
        rdat_nxt = '0;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      rdat_r <= '0;
    end else if (wb_req && !i_wb_we) begin
      rdat_r <= rdat_nxt;
    end else begin
      rdat_r <= '0;
    end
  end

  assign o_wb_ack = ack_r;
  assign o_wb_dat = rdat_r;

endmodule // poled_top

// >>> dv/poled_led_model.sv
/*
  Indicator LEDs with strap resistors on the A pins of the port owner LED driver.
  Assumes value and active-low output enable per pin from the driver.
*/
`timescale 1ns/1ps
module poled_led_model
  import poled_pkg::*;
#(
  parameter logic [NUM_PORTS-1:0] P_STRAP = 4'h5
) (
  input wire logic [NUM_PORTS-1:0] i_val,
  input wire logic [NUM_PORTS-1:0] i_oe_n,
  output logic [NUM_PORTS-1:0] o_pad
);
  // A floating pin settles to its strap resistor level
  assign o_pad = (i_oe_n & P_STRAP) | (~i_oe_n & i_val);
endmodule // poled_led_model

// >>> dv/poled_top_assertions.sv
/*
  Port checker for the port owner LED driver.
  Assumes one clock and that mode is only changed by full Wishbone writes.
*/
`timescale 1ns/1ps
module poled_top_assertions
  import poled_pkg::*;
#(
  parameter int P_TOGGLE_HALF_CYC = TOGGLE_HALF_CYC,
  parameter int P_STRAP_DELAY_CYC = STRAP_DELAY_CYC
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [31:0] i_wb_dat,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] o_wb_dat,
  input wire logic o_wb_ack,
  input wire poled_port_type [NUM_PORTS-1:0] i_port_stat,
  input wire logic i_hub_suspend,
  input wire logic [NUM_PORTS-1:0] o_host_a_indicator_pins,
  input wire logic [NUM_PORTS-1:0] o_host_a_indicator_pins_oe_n,
  input wire logic [NUM_PORTS-1:0] o_host_b_indicator_pins,
  input wire logic [NUM_PORTS-1:0] o_host_b_indicator_pins_oe_n
);
  logic [1:0] mode_r;
  logic [7:0] cnt_r;
  logic quiet;
  logic run;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  ////////////////////////////////////////////////////////////////////////////////
  // Shadow of the mode; bus activity windows are skipped since the copy lags
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      mode_r <= MODE_USB;
    end else if (o_wb_ack && i_wb_we && i_wb_adr == REG_CTRL_OFS && i_wb_sel[0]
                 && i_wb_dat[1:0] != 2'h3) begin
      mode_r <= i_wb_dat[1:0];
    end
  end
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      cnt_r <= 8'h00;
    end else if (cnt_r != 8'hff) begin
      cnt_r <= cnt_r + 8'h01;
    end
  end
  assign quiet = !(i_wb_cyc && i_wb_stb) && !o_wb_ack;
  assign run = int'(cnt_r) > P_STRAP_DELAY_CYC + 2;
  ////////////////////////////////////////////////////////////////////////////////
  a_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack longer than one cycle");
  a_ack_latency: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
    else $error("ack late");
  a_dat_idle: assert property (!o_wb_ack |-> o_wb_dat == 32'h0) else $error("data without ack");
  a_reset_dark: assert property (disable iff (1'b0) !i_nrst |=>
    (&o_host_a_indicator_pins_oe_n) && (&o_host_b_indicator_pins_oe_n))
    else $error("driven in reset");
  a_usb_drive: assert property (quiet && run && mode_r == MODE_USB |=>
    !(|o_host_a_indicator_pins_oe_n) && !(|o_host_b_indicator_pins_oe_n))
    else $error("usb not driven");
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    a_nonown_a: assert property (quiet && mode_r == MODE_SPEED &&
      !(i_port_stat[p].enabled && i_port_stat[p].owner == OWN_A) |=>
      o_host_a_indicator_pins_oe_n[p])
      else $error("a pin driven without ownership");
    a_nonown_b: assert property (quiet && mode_r == MODE_SPEED &&
      !(i_port_stat[p].enabled && i_port_stat[p].owner == OWN_B) |=>
      o_host_b_indicator_pins_oe_n[p])
      else $error("b pin driven without ownership");
    a_speed_level: assert property (quiet && run && mode_r == MODE_SPEED &&
      i_port_stat[p].enabled && i_port_stat[p].owner == OWN_A && i_port_stat[p].attached |=>
      !o_host_a_indicator_pins_oe_n[p] &&
      o_host_a_indicator_pins[p] == $past(i_port_stat[p].high_speed))
      else $error("speed level wrong");
    a_susp_dark: assert property (quiet && mode_r == MODE_SPEED && i_hub_suspend &&
      i_port_stat[p].enabled && i_port_stat[p].owner == OWN_A && !i_port_stat[p].attached |=>
      o_host_a_indicator_pins_oe_n[p]) else $error("empty port lit in suspend");
  end
endmodule // poled_top_assertions
bind poled_top poled_top_assertions #(.P_TOGGLE_HALF_CYC(P_TOGGLE_HALF_CYC),
  .P_STRAP_DELAY_CYC(P_STRAP_DELAY_CYC)) u_chk (.i_clk(i_clk), .i_nrst(i_nrst),
  .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr),
  .i_wb_dat(i_wb_dat), .i_wb_sel(i_wb_sel), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
  .i_port_stat(i_port_stat), .i_hub_suspend(i_hub_suspend),
  .o_host_a_indicator_pins(o_host_a_indicator_pins),
  .o_host_a_indicator_pins_oe_n(o_host_a_indicator_pins_oe_n),
  .o_host_b_indicator_pins(o_host_b_indicator_pins),
  .o_host_b_indicator_pins_oe_n(o_host_b_indicator_pins_oe_n));

// >>> dv/poled_top_tb.sv
/*
  Self-checking bench of the port owner LED driver: mode table, toggle, resets.
  Assumes straps 4'h5 on the A pins and shortened strap and toggle counts.
*/
`timescale 1ns/1ps
module poled_top_tb
  import poled_pkg::*;
;
  localparam int HALF = 4;
  typedef struct packed {
    logic [1:0] mode;
    poled_port_type ps;
    logic susp;
    logic [15:0] exp;
  } poled_tb_row_type;
  // Pins as {a_oe_n, a_val, b_oe_n, b_val}; a floating value reads 0
  localparam poled_tb_row_type ROWS [13] = '{
    '{2'h0, '{1'b1, OWN_B, 1'b0, 1'b0, 1'b1, 1'b0}, 1'b0, 16'h0a0f},
    '{2'h0, '{1'b1, OWN_A, 1'b0, 1'b0, 1'b0, 1'b1}, 1'b0, 16'h0500},
    '{2'h1, '{1'b1, OWN_A, 1'b0, 1'b0, 1'b0, 1'b0}, 1'b0, 16'h0a0f},
    '{2'h1, '{1'b1, OWN_B, 1'b0, 1'b0, 1'b0, 1'b0}, 1'b0, 16'h0500},
    '{2'h1, '{1'b0, OWN_A, 1'b0, 1'b0, 1'b0, 1'b0}, 1'b0, 16'h050f},
    '{2'h1, '{1'b1, OWN_A, 1'b0, 1'b0, 1'b0, 1'b0}, 1'b1, 16'h0a0f},
    '{2'h2, '{1'b1, OWN_A, 1'b1, 1'b1, 1'b0, 1'b0}, 1'b0, 16'h0ff0},
    '{2'h2, '{1'b1, OWN_A, 1'b1, 1'b0, 1'b0, 1'b0}, 1'b0, 16'h00f0},
    '{2'h2, '{1'b1, OWN_B, 1'b1, 1'b1, 1'b0, 1'b0}, 1'b0, 16'hf00f},
    '{2'h2, '{1'b1, OWN_A, 1'b1, 1'b1, 1'b0, 1'b0}, 1'b1, 16'h0ff0},
    '{2'h2, '{1'b1, OWN_A, 1'b0, 1'b0, 1'b0, 1'b0}, 1'b1, 16'hf0f0},
    '{2'h2, '{1'b0, OWN_A, 1'b1, 1'b0, 1'b0, 1'b0}, 1'b0, 16'hf0f0},
    '{2'h2, '{1'b1, OWN_NONE, 1'b1, 1'b0, 1'b0, 1'b0}, 1'b0, 16'hf0f0}
  };
  logic i_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [31:0] wb_dat = 32'h0, rd_dat;
  logic [3:0] wb_sel = 4'h0;
  logic [31:0] o_wb_dat;
  logic o_wb_ack, hub_susp = 1'b0;
  poled_port_type [NUM_PORTS-1:0] port_stat = '0;
  logic [NUM_PORTS-1:0] pad_a, a_val, a_oe_n, b_val, b_oe_n;
  logic [15:0] pin_view;
  int errors = 0, comparisons = 0, n;
  assign pin_view = {a_oe_n, a_val & ~a_oe_n, b_oe_n, b_val & ~b_oe_n};
  always #25 i_clk = ~i_clk;
  ////////////////////////////////////////////////////////////////////////////////
  poled_top #(.P_TOGGLE_HALF_CYC(HALF), .P_STRAP_DELAY_CYC(5)) dut (.i_clk(i_clk),
    .i_nrst(i_nrst), .i_wb_cyc(wb_cyc), .i_wb_stb(wb_stb), .i_wb_we(wb_we),
    .i_wb_adr(wb_adr), .i_wb_dat(wb_dat), .i_wb_sel(wb_sel), .o_wb_dat(o_wb_dat),
    .o_wb_ack(o_wb_ack), .i_port_stat(port_stat), .i_hub_suspend(hub_susp),
    .i_host_a_indicator_pins(pad_a), .o_host_a_indicator_pins(a_val),
    .o_host_a_indicator_pins_oe_n(a_oe_n), .o_host_b_indicator_pins(b_val),
    .o_host_b_indicator_pins_oe_n(b_oe_n));
  poled_led_model #(.P_STRAP(4'h5)) u_leds (.i_val(a_val), .i_oe_n(a_oe_n), .o_pad(pad_a));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d);
    int k;
    @(posedge i_clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_dat <= d;
    wb_sel <= 4'hf;
    k = 0;
    do begin
      @(posedge i_clk);
      k++;
    end while (o_wb_ack !== 1'b1 && k < 20);
    rd_dat = o_wb_dat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    if (k >= 20) begin errors++; give_verdict(); end
  endtask
  // Waits for the next level change of the first A pin; a stuck pin is a timeout
  task automatic wait_flip(output int m);
    logic v;
    v = a_val[0];
    m = 0;
    do begin
      @(posedge i_clk);
      m++;
    end while (a_val[0] === v && m < 50);
    if (m >= 50) begin errors++; give_verdict(); end
  endtask
  task automatic do_reset;
    i_nrst <= 1'b0;
    repeat (16) @(posedge i_clk);
    chk({16'h0, pin_view & 16'hf0f0}, 32'h0000f0f0);
    i_nrst <= 1'b1;
    repeat (2) @(posedge i_clk);
    chk({16'h0, pin_view & 16'hf0f0}, 32'h0000f0f0);
    repeat (10) @(posedge i_clk);
    wb(1'b0, REG_STAT_OFS, 32'h0);
    chk(rd_dat, 32'h0000f515);
    wb(1'b0, REG_CTRL_OFS, 32'h0);
    chk(rd_dat, 32'h0000ff04);
    wb(1'b0, 8'h0c, 32'h0);
    chk(rd_dat, 32'h0);
    $display("reset test done");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    do_reset();
    foreach (ROWS[i]) begin
      port_stat <= {NUM_PORTS{ROWS[i].ps}};
      hub_susp <= ROWS[i].susp;
      wb(1'b1, REG_CTRL_OFS, 32'h0000ff04 | {30'h0, ROWS[i].mode});
      repeat (3) @(posedge i_clk);
      chk({16'h0, pin_view}, {16'h0, ROWS[i].exp});
    end
    $display("mode table test done");
    port_stat <= {NUM_PORTS{poled_port_type'({1'b1, OWN_A, 4'h0})}};
    hub_susp <= 1'b0;
    // The first flip may be the pin turning on mid-phase, so time the third
    wait_flip(n);
    wait_flip(n);
    wait_flip(n);
    chk(n, HALF);
    chk({28'h0, a_oe_n}, 32'h0);
    $display("toggle test done");
    wb(1'b1, REG_CTRL_OFS, 32'h0000ff07);
    wb(1'b0, REG_CTRL_OFS, 32'h0);
    chk(rd_dat, 32'h0000ff06);
    $display("refused mode test done");
    // Distinct ports, software polarity and hub suspend in owner mode
    port_stat <= {poled_port_type'({1'b1, OWN_NONE, 4'h0}),
                  poled_port_type'({1'b0, OWN_A, 4'h0}),
                  poled_port_type'({1'b1, OWN_B, 4'h0}),
                  poled_port_type'({1'b1, OWN_A, 4'h0})};
    hub_susp <= 1'b1;
    wb(1'b1, REG_CTRL_OFS, 32'h0000a501);
    repeat (3) @(posedge i_clk);
    chk({16'h0, pin_view}, 32'h00000408);
    wb(1'b0, REG_STAT_OFS, 32'h0);
    chk(rd_dat, 32'h0000a535);
    wb(1'b0, REG_PINS_OFS, 32'h0);
    chk(rd_dat, 32'h00004100);
    hub_susp <= 1'b0;
    $display("port map test done");
    do_reset();
    give_verdict();
  end
endmodule // poled_top_tb
